// ==== design/pdp_port_ctrl.sv ====
// Notes on behaviour
// - Aux data register at 0x0001, bits 1..0, upper bits read zero, reset zero.
// - Aux data read gives stored bit when direction is 1, else pin.
// - General purpose output drives the stored data bit onto its pin.
// - Enabled oscillator takes over aux pins one and zero.
// - Main direction register at 0x0002, eight bits, reset zero, 1 is output.
// - Enabled SPI forces main pins 3..0 direction; stored bits stay as written.
// - Aux direction bits 1..0; oscillator bypasses them without changing them.
// - Pull bit 6 enables debug pin pull-up only while that pin is input.
// - Pull bit 1 enables pull-downs on aux input pins; reset enabled.
// - Active oscillator turns aux pull-downs off; the enable bit keeps value.
// - All registers here read and write anytime.
// - Pin state for data reads passes a two-stage synchronizer first.
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`default_nettype none
module pdp_port_ctrl
   import pdp_pkg::*;
(
   // Clock and reset
   input wire logic CLK_IN,
   input wire logic RST_B_IN,
   // Register port
   input wire logic [ADDR_W-1:0] REG_ADDR_IN,
   input wire logic [DATA_W-1:0] REG_WDATA_IN,
   input wire logic REG_WR_IN,
   input wire logic REG_RD_IN,
   output logic [DATA_W-1:0] REG_RDATA_OUT,
   // Main port pins
   output logic [MAIN_W-1:0] MAIN_PIN_OE_B_OUT,
   // SPI override
   input wire logic SPI_EN_IN,
   input wire logic [SPI_W-1:0] SPI_DIR_IN,
   // Aux port pins
   input wire logic [AUX_W-1:0] AUX_PIN_IN,
   output logic [AUX_W-1:0] AUX_PIN_OUT,
   output logic [AUX_W-1:0] AUX_PIN_OE_B_OUT,
   output logic [AUX_W-1:0] AUX_PULLDOWN_OUT,
   // Oscillator module
   input wire logic OSC_EN_IN,
   input wire logic OSC_DRIVE_IN,
   output logic OSC_CLK_OUT,
   // Debug pin
   input wire logic DEBUG_PIN_DRIVE_IN,
   output logic DEBUG_PULLUP_OUT
);

   // ---------------------------------------------
   // Decode
   // ---------------------------------------------
   function automatic logic hit(
      input logic [ADDR_W-1:0] addr,
      input logic [ADDR_W-1:0] off
   );
      return addr == off;
   endfunction

   logic [AUX_W-1:0] aux_data_q;
   logic [AUX_W-1:0] aux_dir_q;
   logic [MAIN_W-1:0] main_dir_q;
   logic dbg_pu_q;
   logic aux_pd_q;
   logic [AUX_W-1:0] aux_sync1_q;
   logic [AUX_W-1:0] aux_sync2_q;
   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] rdata_d;

   wire sel_aux_data = hit(REG_ADDR_IN, OFF_AUX_DATA);
   wire sel_main_dir = hit(REG_ADDR_IN, OFF_MAIN_DIR);
   wire sel_aux_dir = hit(REG_ADDR_IN, OFF_AUX_DIR);
   wire sel_pull = hit(REG_ADDR_IN, OFF_PULL);
   wire wr_aux_data = REG_WR_IN & sel_aux_data;
   wire wr_main_dir = REG_WR_IN & sel_main_dir;
   wire wr_aux_dir = REG_WR_IN & sel_aux_dir;
   wire wr_pull = REG_WR_IN & sel_pull;

   // ---------------------------------------------
   // Read path
   // ---------------------------------------------
   // Direction register picks stored value or synchronized pin, per bit
   wire [AUX_W-1:0] aux_rd_bits = (aux_dir_q & aux_data_q) | (~aux_dir_q & aux_sync2_q);
   wire [DATA_W-1:0] aux_data_rd = {6'h00, aux_rd_bits};
   wire [DATA_W-1:0] aux_dir_rd = {6'h00, aux_dir_q};
   wire [DATA_W-1:0] pull_rd = {1'b0, dbg_pu_q, 4'h0, aux_pd_q, 1'b0};
   // Unmapped addresses read as zero rather than stale data
   wire [DATA_W-1:0] rd_mux = sel_aux_data ? aux_data_rd :
                              sel_main_dir ? main_dir_q :
                              sel_aux_dir ? aux_dir_rd :
                              sel_pull ? pull_rd : RDATA_IDLE;

   always_comb begin
      rdata_d = REG_RD_IN ? rd_mux : RDATA_IDLE;
   end

   // ---------------------------------------------
   // Registers
   // ---------------------------------------------
   always_ff @(posedge CLK_IN) begin
      if (!RST_B_IN) begin
         aux_data_q <= AUX_DATA_RST;
      end else if (wr_aux_data) begin
         aux_data_q <= REG_WDATA_IN[AUX_W-1:0];
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (!RST_B_IN) begin
         main_dir_q <= MAIN_DIR_RST;
      end else if (wr_main_dir) begin
         main_dir_q <= REG_WDATA_IN;
      end
   end

   // Override signals never touch the stored bits
   always_ff @(posedge CLK_IN) begin
      if (!RST_B_IN) begin
         aux_dir_q <= AUX_DIR_RST;
      end else if (wr_aux_dir) begin
         aux_dir_q <= REG_WDATA_IN[AUX_W-1:0];
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (!RST_B_IN) begin
         dbg_pu_q <= PULL_DBG_RST;
         aux_pd_q <= PULL_AUX_RST;
      end else if (wr_pull) begin
         dbg_pu_q <= REG_WDATA_IN[PULL_DBG_BIT];
         aux_pd_q <= REG_WDATA_IN[PULL_AUX_BIT];
      end
   end

   // Two stages, so reads lag the pin by up to three cycles
   always_ff @(posedge CLK_IN) begin
      if (!RST_B_IN) begin
         aux_sync1_q <= 2'h0;
         aux_sync2_q <= 2'h0;
      end else begin
         aux_sync1_q <= AUX_PIN_IN;
         aux_sync2_q <= aux_sync1_q;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (!RST_B_IN) begin
         rdata_q <= RDATA_IDLE;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign REG_RDATA_OUT = rdata_q;

   // ---------------------------------------------
   // Pin control
   // ---------------------------------------------
   // No ordering of data and direction writes is enforced here; a direction
   // write ahead of the data write glitches the pin for a cycle.
   wire [SPI_W-1:0] low_dir = SPI_EN_IN ? SPI_DIR_IN : main_dir_q[SPI_W-1:0];
   wire [MAIN_W-1:0] main_dir_eff = {main_dir_q[MAIN_W-1:SPI_W], low_dir};

   assign MAIN_PIN_OE_B_OUT = ~main_dir_eff;

   wire [AUX_W-1:0] gp_pin_out = aux_data_q;
   wire [AUX_W-1:0] gp_oe_b = ~aux_dir_q;

   assign AUX_PIN_OUT = OSC_EN_IN ? {OSC_DRIVE_IN, 1'b0} : gp_pin_out;
   assign AUX_PIN_OE_B_OUT = OSC_EN_IN ? OSC_OE_B : gp_oe_b;
   // Analog clock path to the oscillator; it is not sampled by this logic
   assign OSC_CLK_OUT = AUX_PIN_IN[0];

   wire pd_active = aux_pd_q & ~OSC_EN_IN;
   assign AUX_PULLDOWN_OUT = {AUX_W{pd_active}} & ~aux_dir_q;
   assign DEBUG_PULLUP_OUT = dbg_pu_q & ~DEBUG_PIN_DRIVE_IN;

   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (!RST_B_IN);

   wire rd_aux_data = REG_RD_IN & sel_aux_data;
   wire rd_pull = REG_RD_IN & sel_pull;
   wire rd_aux_dir = REG_RD_IN & sel_aux_dir;

   a_aux_upper_zero: assert property (
      rd_aux_data |=> REG_RDATA_OUT[7:2] == 6'h00
   ) else $error("aux data upper bits not zero");

   a_aux_read_stored: assert property (
      rd_aux_data && aux_dir_q == 2'h3 |=> REG_RDATA_OUT[1:0] == $past(aux_data_q)
   ) else $error("aux data read not stored value");

   a_aux_gp_drive: assert property (
      !OSC_EN_IN && aux_dir_q[1] |-> AUX_PIN_OUT[1] == aux_data_q[1] && !AUX_PIN_OE_B_OUT[1]
   ) else $error("aux pin one not driven from data");

   a_aux_write_drive: assert property (
      wr_aux_data && !OSC_EN_IN ##1 !OSC_EN_IN && aux_dir_q[0]
      |-> AUX_PIN_OUT[0] == $past(REG_WDATA_IN[0])
   ) else $error("aux pin zero lost written value");

   a_osc_takeover: assert property (
      OSC_EN_IN |-> AUX_PIN_OUT[1] == OSC_DRIVE_IN && AUX_PIN_OE_B_OUT == OSC_OE_B
   ) else $error("oscillator does not own aux pins");

   a_main_dir_reset: assert property (
      disable iff (1'b0) !RST_B_IN |=> main_dir_q == MAIN_DIR_RST && aux_data_q == AUX_DATA_RST
   ) else $error("register not cleared by reset");

   a_main_upper_dir: assert property (
      wr_main_dir |=> MAIN_PIN_OE_B_OUT[7:4] == ~$past(REG_WDATA_IN[7:4])
   ) else $error("main upper direction not applied");

   a_spi_force: assert property (
      SPI_EN_IN |-> MAIN_PIN_OE_B_OUT[3:0] == ~SPI_DIR_IN
   ) else $error("spi direction not forced");

   a_spi_keeps_bits: assert property (
      SPI_EN_IN && !wr_main_dir |=> $stable(main_dir_q)
   ) else $error("spi override changed stored direction");

   a_osc_keeps_dir: assert property (
      OSC_EN_IN && !wr_aux_dir |=> $stable(aux_dir_q)
   ) else $error("oscillator changed aux direction");

   a_dbg_pullup: assert property (
      DEBUG_PULLUP_OUT == (dbg_pu_q && !DEBUG_PIN_DRIVE_IN)
   ) else $error("debug pull-up wrong");

   a_pull_reset: assert property (
      disable iff (1'b0) !RST_B_IN |=> dbg_pu_q && aux_pd_q
   ) else $error("pull enables not set by reset");

   a_aux_pulldown: assert property (
      !OSC_EN_IN && aux_pd_q |-> AUX_PULLDOWN_OUT == ~aux_dir_q
   ) else $error("aux pull-downs wrong");

   a_osc_pd_off: assert property (
      OSC_EN_IN |-> AUX_PULLDOWN_OUT == 2'h0
   ) else $error("pull-downs on under oscillator");

   a_osc_pd_bit_kept: assert property (
      OSC_EN_IN && !wr_pull |=> $stable(aux_pd_q)
   ) else $error("oscillator changed pull-down bit");

   a_write_anytime: assert property (
      wr_main_dir ##1 REG_RD_IN && sel_main_dir |=> REG_RDATA_OUT == $past(REG_WDATA_IN, 2)
   ) else $error("main direction readback mismatch");

   a_sync_delay: assert property (
      rd_aux_data && aux_dir_q == 2'h0 |=> REG_RDATA_OUT[1:0] == $past(AUX_PIN_IN, 3)
   ) else $error("pin read not synchronized");

   a_pull_unimpl: assert property (
      rd_pull |=> (REG_RDATA_OUT & ~PULL_MASK) == 8'h00
   ) else $error("pull unimplemented bits set");

   a_dir_unimpl: assert property (
      rd_aux_dir |=> (REG_RDATA_OUT & ~AUX_MASK) == 8'h00
   ) else $error("aux direction unimplemented bits set");

   a_idle_rdata: assert property (
      !REG_RD_IN |=> REG_RDATA_OUT == RDATA_IDLE
   ) else $error("read data outside read slot");

   c_pin_read: cover property (
      rd_aux_data && aux_dir_q == 2'h0 ##1 REG_RDATA_OUT[1:0] != 2'h0
   );

   c_osc_enable: cover property (
      !OSC_EN_IN ##1 OSC_EN_IN && aux_pd_q
   );

   c_spi_override: cover property (
      SPI_EN_IN && SPI_DIR_IN != main_dir_q[3:0]
   );

   c_data_then_dir: cover property (
      wr_aux_data ##1 wr_aux_dir
   );

endmodule
`default_nettype wire

// ==== design/pdp_pkg.sv ====
`default_nettype none
package pdp_pkg;
   // ---------------------------------------------
   // Register map
   // ---------------------------------------------
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam logic [15:0] OFF_AUX_DATA = 16'h0001;
   localparam logic [15:0] OFF_MAIN_DIR = 16'h0002;
   localparam logic [15:0] OFF_AUX_DIR = 16'h0003;
   localparam logic [15:0] OFF_PULL = 16'h000C;

   // ---------------------------------------------
   // Field widths and positions
   // ---------------------------------------------
   localparam int AUX_W = 2;
   localparam int MAIN_W = 8;
   localparam int SPI_W = 4;
   localparam int PULL_DBG_BIT = 6;
   localparam int PULL_AUX_BIT = 1;
   localparam logic [7:0] PULL_MASK = 8'h42;
   localparam logic [7:0] AUX_MASK = 8'h03;

   // ---------------------------------------------
   // Reset values
   // ---------------------------------------------
   localparam logic [1:0] AUX_DATA_RST = 2'h0;
   localparam logic [1:0] AUX_DIR_RST = 2'h0;
   localparam logic [7:0] MAIN_DIR_RST = 8'h00;
   localparam logic PULL_DBG_RST = 1'b1;
   localparam logic PULL_AUX_RST = 1'b1;
   localparam logic [7:0] RDATA_IDLE = 8'h00;

   // ---------------------------------------------
   // Pin enable codes, low means driven
   // ---------------------------------------------
   // Oscillator drives aux pin one; aux pin zero stays an input to it
   localparam logic [1:0] OSC_OE_B = 2'h1;
endpackage
`default_nettype wire

// ==== verif/pdp_pad_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------
// Aux pad wires
// ----------------
module pdp_pad_model (
   input wire logic clk_in,
   input wire logic [1:0] out_in,
   input wire logic [1:0] oe_b_in,
   input wire logic [1:0] pd_in,
   input wire logic [1:0] ext_en_in,
   input wire logic [1:0] ext_val_in,
   output logic [1:0] pin_out
);
   // A floating pad toggles, so a missing pull never reads as a stable level
   logic float_q = 1'b0;
   always_ff @(posedge clk_in) begin
      float_q <= ~float_q;
   end
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         if (!oe_b_in[i]) pin_out[i] = out_in[i];
         else if (ext_en_in[i]) pin_out[i] = ext_val_in[i];
         else if (pd_in[i]) pin_out[i] = 1'b0;
         else pin_out[i] = float_q;
      end
   end
endmodule
`default_nettype wire

// ==== verif/port_data_direction_pull_ctrl_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module port_data_direction_pull_ctrl_tb_top;
   import pdp_pkg::*;
   // ----------------
   // Stimulus and wires
   // ----------------
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0, rd = 1'b0, rd_d = 1'b0, spi_en = 1'b0;
   logic osc_en = 1'b0, osc_drv = 1'b0, dbg_drv = 1'b0;
   logic [3:0] spi_dir = 4'h0;
   logic [1:0] ext_en = 2'h0, ext_val = 2'h0, e;
   logic [7:0] v;
   logic [7:0] exp_q[$];
   wire logic [7:0] rdata, main_oe_b;
   wire logic [1:0] aux_pin, aux_out, aux_oe_b, aux_pd;
   wire logic osc_clk, dbg_pu;
   wire logic [7:0] aux_vec = {aux_out, aux_oe_b, aux_pd, osc_clk, dbg_pu};
   int n_mismatch = 0, comparisons = 0, cycles = 0;

   initial begin
      forever #5 clk = ~clk;
   end

   pdp_port_ctrl DUT (.CLK_IN(clk), .RST_B_IN(rst_b), .REG_ADDR_IN(addr),
      .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
      .MAIN_PIN_OE_B_OUT(main_oe_b), .SPI_EN_IN(spi_en), .SPI_DIR_IN(spi_dir),
      .AUX_PIN_IN(aux_pin), .AUX_PIN_OUT(aux_out), .AUX_PIN_OE_B_OUT(aux_oe_b),
      .AUX_PULLDOWN_OUT(aux_pd), .OSC_EN_IN(osc_en), .OSC_DRIVE_IN(osc_drv),
      .OSC_CLK_OUT(osc_clk), .DEBUG_PIN_DRIVE_IN(dbg_drv), .DEBUG_PULLUP_OUT(dbg_pu));

   pdp_pad_model pads (.clk_in(clk), .out_in(aux_out), .oe_b_in(aux_oe_b), .pd_in(aux_pd),
      .ext_en_in(ext_en), .ext_val_in(ext_val), .pin_out(aux_pin));

   // ----------------
   // Tasks
   // ----------------
   task automatic compare(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Each write but the one that clears 0x0003 is followed at once by a read; never call two writes back to back,
   // as that would set the write strobe twice in one step
   task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic reg_rd(input logic [15:0] a, input logic [7:0] x);
      exp_q.push_back(x);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
   endtask

   task automatic conclude;
      $display("Mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ----------------
   // Read monitor and timeout
   // ----------------
   always @(posedge clk) begin
      rd_d <= rd;
      cycles++;
      if (rd_d) compare("read data", exp_q.pop_front(), rdata);
      if (cycles == 2000) begin
         n_mismatch++;
         conclude();
      end
   end

   // ----------------
   // Scenarios
   // ----------------
   initial begin
      void'($urandom(66260));
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      @(negedge clk);
      compare("main oe", 8'hFF, main_oe_b);
      compare("aux pins", 8'h3D, aux_vec);
      @(posedge clk);
      reg_rd(16'h0001, 8'h00);
      reg_rd(16'h0002, 8'h00);
      reg_rd(16'h0003, 8'h00);
      reg_rd(16'h000C, 8'h42);
      reg_rd(16'h0004, 8'h00);
      v = 8'($urandom);
      reg_wr(16'h0002, v);
      reg_rd(16'h0002, v);
      spi_en <= 1'b1;
      spi_dir <= 4'($urandom);
      @(negedge clk);
      compare("main oe", ~{v[7:4], spi_dir}, main_oe_b);
      @(posedge clk);
      reg_rd(16'h0002, v);
      reg_wr(16'h0001, 8'hFF);
      reg_rd(16'h0001, 8'h00);
      reg_wr(16'h0003, 8'hFF);
      reg_rd(16'h0003, 8'h03);
      reg_rd(16'h0001, 8'h03);
      @(negedge clk);
      compare("aux pins", 8'hC3, aux_vec);
      @(posedge clk);
      reg_wr(16'h0003, 8'h00);
      e = 2'($urandom);
      ext_en <= 2'h3;
      ext_val <= e;
      dbg_drv <= 1'b1;
      repeat (5) @(posedge clk);
      reg_rd(16'h0001, {6'h00, e});
      compare("aux pins", {6'h3F, e[0], 1'b0}, aux_vec);
      reg_wr(16'h000C, 8'h00);
      reg_rd(16'h000C, 8'h00);
      compare("aux pins", {6'h3C, e[0], 1'b0}, aux_vec);
      reg_wr(16'h000C, 8'hFF);
      reg_rd(16'h000C, 8'h42);
      ext_en <= 2'h1;
      osc_en <= 1'b1;
      osc_drv <= 1'b1;
      dbg_drv <= 1'b0;
      repeat (5) @(posedge clk);
      compare("aux pins", {6'h24, e[0], 1'b1}, aux_vec);
      reg_rd(16'h0001, {7'h01, e[0]});
      reg_rd(16'h000C, 8'h42);
      reg_rd(16'h0003, 8'h00);
      repeat (2) @(posedge clk);
      conclude();
   end
endmodule
`default_nettype wire
